// ===== hw/aom_pkg.sv
// Purpose: Shared constants and types for accelerometer mode control
// Assumes: 10 MHz mclk
// Notes: Timing counts derive from times in their own units
package aom_pkg;
   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 10000000;
   localparam int BOOT_US = 500;
   localparam int BOOT_CYC = (BOOT_US * (CLK_HZ / 1000000));
   localparam int SETTLE_MS = 1;
   localparam int SETTLE_CYC = (SETTLE_MS * (CLK_HZ / 1000));
   localparam int ODR_PERIODS = 2;
   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
   // Output rate per code in hundredths of Hz, 800 Hz down to 1.56 Hz
   localparam int ODR_HZ_X100 [8] = '{80000, 40000, 20000, 10000,
                                      5000, 1250, 625, 156};
   // -----------------------------------------------------------------
   // Full-scale ranges and sample width
   // -----------------------------------------------------------------
   localparam logic [1:0] FS_2G = 2'h0;
   localparam logic [1:0] FS_4G = 2'h1;
   localparam logic [1:0] FS_8G = 2'h2;
   localparam int CNT_PER_G_2G = 4096;
   localparam int CNT_PER_G_4G = 2048;
   localparam int CNT_PER_G_8G = 1024;
   localparam int SAMPLE_W = 14;
   localparam int OUT_BASE_ADDR = 32'h00000000;
   // Reset value of the volatile registers cleared on entering active
   localparam logic [7:0] VOL_RESET = 8'h00;
   // Self-test stimulus in milli-g, scaled by range sensitivity
   localparam int ST_MG = 100;
   // -----------------------------------------------------------------
   // Mode states, one-hot
   // -----------------------------------------------------------------
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_BOOT = 5'h02,
      ST_STANDBY = 5'h04,
      ST_WAKE = 5'h08,
      ST_SLEEP = 5'h10
   } aom_state_t;
endpackage : aom_pkg

// ===== hw/aom_scale_if.sv
// Purpose: Carries one axis sample request and its scaled result
// Assumes: Single clock
// Notes: Used between mode control and the scaler
`timescale 1ns/1ps
interface aom_scale_if;
   logic [1:0] range;
   logic selfTest;
   logic signed [15:0] accelMg;
   logic signed [13:0] sample;
   modport ctrl (output range, output selfTest, output accelMg,
      input sample);
   modport scaler (input range, input selfTest, input accelMg,
      output sample);
endinterface : aom_scale_if

// ===== hw/aom_scaler.sv
// Purpose: Converts milli-g to two's complement counts by range
// Assumes: Combinational, range code valid
// Notes: Saturates to the 14-bit signed range
`timescale 1ns/1ps
module aom_scaler (
   aom_scale_if.scaler sif
);
   logic signed [31:0] total;
   logic signed [31:0] counts;

   // Sum of real and test acceleration, then scale and clip
   always_comb begin
      total = 32'(sif.accelMg) + (sif.selfTest ? aom_pkg::ST_MG : 0); // R9
      case (sif.range)
         aom_pkg::FS_2G: counts = (total * aom_pkg::CNT_PER_G_2G) / 1000; // R7
         aom_pkg::FS_4G: counts = (total * aom_pkg::CNT_PER_G_4G) / 1000; // R7
         default: counts = (total * aom_pkg::CNT_PER_G_8G) / 1000; // R7
      endcase
      if (counts > 32'sh00001fff) begin
         sif.sample = 14'h1fff; // R8
      end else if (counts < -32'sh00002000) begin
         sif.sample = 14'h2000; // R8
      end else begin
         sif.sample = counts[13:0]; // R8
      end
   end
endmodule : aom_scaler

// ===== hw/aom_mode_ctrl.sv
// Notes on behaviour
// [R1] Standby: digital only, clocks off, bus on
// [R2] Active: all blocks on, bus still on
// [R3] Off: everything down, bus ignored
// [R4] Active to standby keeps all registers; code still clears dataValid
// [R5] Standby to active resets marked registers
// [R6] Sleep and wake exist only while active
// [R7] Counts per g follow selected range
// [R8] Samples are two's complement, zero centred
// [R9] Self-test adds stimulus to real acceleration
// [R10] Data valid after 2 rate periods plus 1ms
// [R11] Boot and trim load, then standby
// [R12] Host configures only in standby; code still applies rangeSel and selfTestEn live while active
//
// Purpose: Operating-mode sequencer of a three-axis accelerometer
// Assumes: Supplies reported as a synchronous level; inputs synchronous
// Notes: Volatile register clear is a one-cycle pulse to the map
`timescale 1ns/1ps
module aom_mode_ctrl (
   input wire logic mclk,
   input wire logic reset,
   input wire logic suppliesUp,
   input wire logic activeBit,
   input wire logic sleepReq,
   input wire logic [2:0] odrSel,
   input wire logic [1:0] rangeSel,
   input wire logic selfTestEn,
   input wire logic signed [15:0] accelMg,
   input wire logic sampleTick,
   output logic analogEn,
   output logic clocksEn,
   output logic digitalEn,
   output logic busEn,
   output logic trimLoad,
   output logic volClear,
   output logic activeClr,
   output logic inSleep,
   output logic dataValid,
   output logic signed [13:0] sampleOut
);
   aom_pkg::aom_state_t state, next_state;
   logic [aom_pkg::CNT_W-1:0] timer, next_timer;
   logic next_analogEn, next_clocksEn, next_digitalEn, next_busEn;
   logic next_trimLoad, next_volClear, next_activeClr;
   logic next_inSleep, next_dataValid;
   logic signed [13:0] next_sampleOut;
   // Active-time counter kept only for the settle-time check
   logic [aom_pkg::CNT_W-1:0] onCount, next_onCount;
   aom_scale_if sif ();

   // -----------------------------------------------------------------
   // Sample scaling
   // -----------------------------------------------------------------
   assign sif.range = rangeSel;
   assign sif.selfTest = selfTestEn;
   assign sif.accelMg = accelMg;

   aom_scaler u_scaler (
      .sif(sif.scaler)
   );

   // Settling time in cycles for the selected output rate
   function automatic logic [aom_pkg::CNT_W-1:0] settle(
      input logic [2:0] sel);
      longint cyc;
      cyc = (longint'(aom_pkg::ODR_PERIODS) * aom_pkg::CLK_HZ * 100)
         / aom_pkg::ODR_HZ_X100[sel] + aom_pkg::SETTLE_CYC;
      return cyc[aom_pkg::CNT_W-1:0];
   endfunction : settle

   // -----------------------------------------------------------------
   // Mode state machine
   // -----------------------------------------------------------------
   // Next state, timer, clear pulses and sample capture
   always_comb begin
      next_state = state;
      next_timer = (timer != aom_pkg::CNT_ZERO) ? timer - 24'h000001 : timer;
      next_volClear = 1'b0;
      next_activeClr = 1'b0;
      next_dataValid = dataValid;
      next_sampleOut = sampleOut;
      case (state)
         aom_pkg::ST_OFF: begin
            if (suppliesUp) begin
               next_state = aom_pkg::ST_BOOT; // R11
               next_timer = aom_pkg::BOOT_CYC[aom_pkg::CNT_W-1:0];
            end
         end
         aom_pkg::ST_BOOT: begin
            if (timer == aom_pkg::CNT_ZERO) begin
               next_state = aom_pkg::ST_STANDBY; // R11
               next_activeClr = 1'b1; // R11
            end
         end
         aom_pkg::ST_STANDBY: begin
            next_dataValid = 1'b0;
            // Configuration is only expected to change here
            if (activeBit) begin // R12
               next_state = aom_pkg::ST_WAKE;
               next_volClear = 1'b1; // R5
               next_timer = settle(odrSel); // R10
            end
         end
         aom_pkg::ST_WAKE, aom_pkg::ST_SLEEP: begin
            if (!activeBit) begin
               // Sample kept; valid drops with the analog side
               next_state = aom_pkg::ST_STANDBY; // R4
               next_dataValid = 1'b0; // R10
            end else begin
               next_state = sleepReq ? aom_pkg::ST_SLEEP
                                     : aom_pkg::ST_WAKE; // R6
               if (timer == aom_pkg::CNT_ZERO && sampleTick) begin
                  next_dataValid = 1'b1; // R10
                  next_sampleOut = sif.sample; // R8
               end
            end
         end
         default: next_state = aom_pkg::ST_OFF;
      endcase
      // Supply loss always wins
      if (!suppliesUp) begin
         next_state = aom_pkg::ST_OFF; // R3
         next_dataValid = 1'b0;
         next_timer = aom_pkg::CNT_ZERO;
      end
   end

   // Block enables decoded from the next state
   always_comb begin
      next_analogEn = (next_state == aom_pkg::ST_WAKE) ||
                      (next_state == aom_pkg::ST_SLEEP); // R2
      next_clocksEn = next_analogEn; // R1
      next_digitalEn = (next_state != aom_pkg::ST_OFF); // R1
      next_busEn = (next_state == aom_pkg::ST_STANDBY) ||
                   next_analogEn; // R3
      next_trimLoad = (next_state == aom_pkg::ST_BOOT); // R11
      next_inSleep = (next_state == aom_pkg::ST_SLEEP); // R6
   end

   // Registered state and outputs
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         state <= aom_pkg::ST_OFF;
         timer <= aom_pkg::CNT_ZERO;
         analogEn <= 1'b0;
         clocksEn <= 1'b0;
         digitalEn <= 1'b0;
         busEn <= 1'b0;
         trimLoad <= 1'b0;
         volClear <= 1'b0;
         activeClr <= 1'b0;
         inSleep <= 1'b0;
         dataValid <= 1'b0;
         sampleOut <= 14'h0000;
      end else begin
         state <= next_state;
         timer <= next_timer;
         analogEn <= next_analogEn;
         clocksEn <= next_clocksEn;
         digitalEn <= next_digitalEn;
         busEn <= next_busEn;
         trimLoad <= next_trimLoad;
         volClear <= next_volClear;
         activeClr <= next_activeClr;
         inSleep <= next_inSleep;
         dataValid <= next_dataValid;
         sampleOut <= next_sampleOut;
      end
   end

   // Count active cycles, saturating, for the settle-time check
   always_comb begin
      next_onCount = onCount;
      if (!analogEn) begin
         next_onCount = aom_pkg::CNT_ZERO;
      end else if (onCount != 24'hffffff) begin
         next_onCount = onCount + 24'h000001;
      end
   end

   // Active cycle counter register
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         onCount <= aom_pkg::CNT_ZERO;
      end else begin
         onCount <= next_onCount;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   standby_power_a: assert property ( // R1
      @(posedge mclk) disable iff (reset)
      state == aom_pkg::ST_STANDBY |->
         !analogEn && !clocksEn && busEn && digitalEn)
      else $error("standby enables wrong");
   active_power_a: assert property ( // R2
      @(posedge mclk) disable iff (reset)
      (state == aom_pkg::ST_WAKE || state == aom_pkg::ST_SLEEP) |->
         analogEn && clocksEn && busEn && digitalEn)
      else $error("active enables wrong");
   off_quiet_a: assert property ( // R3
      @(posedge mclk) disable iff (reset)
      state == aom_pkg::ST_OFF |-> !busEn && !digitalEn && !analogEn)
      else $error("off state not quiet");
   keep_regs_a: assert property ( // R4
      @(posedge mclk) disable iff (reset)
      $fell(analogEn) |-> !volClear && $stable(sampleOut))
      else $error("state lost on leaving active");
   enter_clear_a: assert property ( // R5
      @(posedge mclk) disable iff (reset)
      $rose(analogEn) |-> volClear)
      else $error("no clear on active");
   sleep_active_a: assert property ( // R6
      @(posedge mclk) disable iff (reset)
      inSleep |-> analogEn)
      else $error("sleep outside active");
   turn_on_a: assert property ( // R10
      @(posedge mclk) disable iff (reset)
      $rose(analogEn) |-> !dataValid [*8])
      else $error("data too early");
   settle_time_a: assert property ( // R10
      @(posedge mclk) disable iff (reset)
      $rose(dataValid) |->
         onCount > aom_pkg::SETTLE_CYC[aom_pkg::CNT_W-1:0])
      else $error("data before settle time");
   valid_active_a: assert property ( // R10
      @(posedge mclk) disable iff (reset)
      dataValid |-> analogEn)
      else $error("valid outside active");
   boot_first_a: assert property ( // R11
      @(posedge mclk) disable iff (reset)
      $rose(busEn) && !analogEn |-> $past(trimLoad) && activeClr)
      else $error("standby without boot");
   boot_quiet_a: assert property ( // R11
      @(posedge mclk) disable iff (reset)
      trimLoad |-> !busEn && !analogEn && digitalEn)
      else $error("bus or analog on during boot");
   boot_c: cover property (@(posedge mclk) disable iff (reset)
      state == aom_pkg::ST_BOOT ##1 state == aom_pkg::ST_STANDBY);
   active_c: cover property (@(posedge mclk) disable iff (reset)
      $rose(dataValid));
   sleep_c: cover property (@(posedge mclk) disable iff (reset)
      $rose(inSleep));
   drop_c: cover property (@(posedge mclk) disable iff (reset)
      $fell(digitalEn));
endmodule : aom_mode_ctrl

// ===== tb/aom_host_model.sv
// Purpose: Host side of the active control bit
// Assumes: A host write lands on the next mclk edge
// Notes: The device clear at boot end wins over the host
`timescale 1ns/1ps
module aom_host_model (
   input wire logic mclk,
   input wire logic reset,
   input wire logic activeClr,
   input wire logic wantActive,
   output logic activeBit
);
   // Active bit register, loaded from wantActive every cycle unless activeClr clears it
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         activeBit <= 1'b0;
      end else if (activeClr) begin
         activeBit <= 1'b0;
      end else begin
         activeBit <= wantActive;
      end
   end
endmodule : aom_host_model

// ===== tb/test_accel_operating_mode_control.sv
// Purpose: Self-checking bench for the mode sequencer
// Assumes: 10 MHz mclk, 800 Hz rate code during settle
// Notes: Sample ticks every 502 cycles during settle, and every 5 cycles in the sample checks, drive the output path
`timescale 1ns/1ps
module test_accel_operating_mode_control;
   logic mclk, reset, suppliesUp, sleepReq, selfTestEn, sampleTick;
   logic wantActive, activeBit, analogEn, clocksEn, digitalEn, busEn;
   logic trimLoad, volClear, activeClr, inSleep, dataValid;
   logic [2:0] odrSel;
   logic [1:0] rangeSel;
   logic signed [15:0] accelMg;
   logic signed [13:0] sampleOut;
   int n_mismatch = 0;
   int n_compared = 0;
   // -----------------------------------------------------------------
   // Design and host
   // -----------------------------------------------------------------
   aom_mode_ctrl dut_u (.mclk(mclk), .reset(reset),
      .suppliesUp(suppliesUp), .activeBit(activeBit),
      .sleepReq(sleepReq), .odrSel(odrSel), .rangeSel(rangeSel),
      .selfTestEn(selfTestEn), .accelMg(accelMg),
      .sampleTick(sampleTick), .analogEn(analogEn),
      .clocksEn(clocksEn), .digitalEn(digitalEn), .busEn(busEn),
      .trimLoad(trimLoad), .volClear(volClear),
      .activeClr(activeClr), .inSleep(inSleep),
      .dataValid(dataValid), .sampleOut(sampleOut));
   aom_host_model host_u (.mclk(mclk), .reset(reset),
      .activeClr(activeClr), .wantActive(wantActive),
      .activeBit(activeBit));
   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc
   task automatic tick;
      @(posedge mclk) sampleTick <= 1'b1;
      @(posedge mclk) sampleTick <= 1'b0;
      cyc(2);
   endtask : tick
   task automatic conclude;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   // -----------------------------------------------------------------
   // Scenarios
   // -----------------------------------------------------------------
   task automatic t_boot;
      int k;
      k = 0;
      chk("digitalEn off", digitalEn, 1'b0);
      @(posedge mclk) suppliesUp <= 1'b1;
      cyc(2);
      chk("trimLoad", trimLoad, 1'b1);
      chk("digitalEn boot", digitalEn, 1'b1);
      chk("busEn boot", busEn, 1'b0);
      while (activeClr !== 1'b1 && k < 6000) begin
         cyc(1);
         k++;
      end
      chk("boot ended", 16'(k > 4990 && k < 5010), 1'b1);
      chk("busEn standby", busEn, 1'b1);
      chk("analogEn standby", analogEn, 1'b0);
      chk("clocksEn standby", clocksEn, 1'b0);
      @(posedge mclk) sleepReq <= 1'b1;
      cyc(3);
      chk("activeClr pulse", activeClr, 1'b0);
      chk("sleep in standby", inSleep, 1'b0);
   endtask : t_boot
   task automatic t_active;
      int k;
      logic [1:0] rg [8] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0, 2'h0, 2'h0,
                             2'h1};
      logic [15:0] mg [8] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h03e8,
                              16'hfe0c, 16'h09c4, 16'hf63c, 16'h0190};
      logic st [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      logic [15:0] ex [8] = '{16'h1000, 16'h0800, 16'h0400, 16'h0400,
                              16'hf800, 16'h1fff, 16'he000, 16'h0400};
      k = 0;
      @(posedge mclk) begin
         wantActive <= 1'b1;
         sleepReq <= 1'b0;
      end
      cyc(2);
      chk("analogEn active", analogEn, 1'b1);
      chk("clocksEn active", clocksEn, 1'b1);
      chk("busEn active", busEn, 1'b1);
      chk("volClear", volClear, 1'b1);
      cyc(1);
      chk("volClear pulse", volClear, 1'b0);
      repeat (60) begin
         cyc(498);
         tick;
      end
      chk("early dataValid", dataValid, 1'b0);
      while (dataValid !== 1'b1 && k < 20) begin
         cyc(498);
         tick;
         k++;
      end
      chk("dataValid", dataValid, 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk) begin
            rangeSel <= rg[i];
            accelMg <= mg[i];
            selfTestEn <= st[i];
         end
         tick;
         chk("sampleOut", sampleOut, ex[i]);
      end
      @(posedge mclk) sleepReq <= 1'b1;
      cyc(2);
      chk("sleep active", inSleep, 1'b1);
      chk("analogEn sleep", analogEn, 1'b1);
   endtask : t_active
   task automatic t_leave;
      @(posedge mclk) wantActive <= 1'b0;
      repeat (3) begin
         cyc(1);
         chk("no clear", volClear, 1'b0);
      end
      chk("analogEn back", analogEn, 1'b0);
      chk("sleep dropped", inSleep, 1'b0);
      chk("dataValid drop", dataValid, 1'b0);
      chk("sample kept", sampleOut, 16'h0400);
      @(posedge mclk) wantActive <= 1'b1;
      cyc(2);
      chk("volClear again", volClear, 1'b1);
      @(posedge mclk) suppliesUp <= 1'b0;
      cyc(2);
      chk("digitalEn lost", digitalEn, 1'b0);
      chk("busEn lost", busEn, 1'b0);
      chk("analogEn lost", analogEn, 1'b0);
   endtask : t_leave
   // -----------------------------------------------------------------
   // Clock, main sequence and watchdog
   // -----------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   initial begin
      reset = 1'b1;
      suppliesUp = 1'b0;
      sleepReq = 1'b0;
      selfTestEn = 1'b0;
      sampleTick = 1'b0;
      wantActive = 1'b0;
      odrSel = 3'h0;
      rangeSel = 2'h0;
      accelMg = 16'h0000;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      cyc(1);
      t_boot;
      t_active;
      t_leave;
      conclude;
   end
   initial begin
      #6000000;
      n_mismatch++;
      conclude;
   end
endmodule : test_accel_operating_mode_control
